// ---- dv/duart_mode1_and_irq_regs_asserts.sv ----
/*
  Port checker of the channel A register block, bound to its top.
  Assumes the constants header is on the include path.
*/
`include "duart_defines.vh"

module duart_regs_checker (
  // clock and reset
  input logic mclk,
  input logic rst_n,
  // register port
  input logic [3:0] addr,
  input logic [7:0] wdata,
  input logic wr_stb,
  input logic rd_stb,
  input logic [7:0] rdata_q,
  // pins
  input logic rxd,
  input logic txd_q,
  input logic [3:0] in_port,
  input logic [7:0] op_n_q,
  input logic irq_n_q
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_SET1 = 16 * `BAUD_DIV_SET1;
  localparam int BIT_SET2 = 16 * `BAUD_DIV_SET2;
  logic set2_q;
  logic [7:0] mask_q;
  logic [7:0] mask_old_q;
  int low_q;

  // ****
  // helper state
  // ****
  always @(posedge mclk) begin
    if (!rst_n) begin
      set2_q <= 1'b0;
      mask_q <= 8'h00;
      mask_old_q <= 8'h00;
      low_q <= 0;
    end else begin
      if (wr_stb && addr == 4'h4) begin
        set2_q <= wdata[7];
      end
      if (wr_stb && addr == 4'h5) begin
        mask_q <= wdata;
      end
      mask_old_q <= mask_q;
      low_q <= txd_q ? 0 : low_q + 1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // ****
  // assertions
  // ****
  property p_reset_pins;
    $rose(rst_n) |-> txd_q && irq_n_q && op_n_q == 8'hff && rdata_q == 8'h00;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("pins not idle");
  property p_read_idle;
    !rd_stb |=> rdata_q == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data without read");
  property p_wo_read;
    rd_stb && (addr == 4'h6 || addr == 4'h7) |=> rdata_q == 8'h00;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only place read back");
  property p_op_set;
    wr_stb && addr == 4'he ##1 !(wr_stb && addr == 4'hf) |=>
      (op_n_q & $past(wdata, 2) & 8'hae) == 8'h00;
  endproperty
  a_op_set: assert property (p_op_set) else $error("set bit pin not low");
  property p_op_clr;
    wr_stb && addr == 4'hf ##1 !(wr_stb && addr == 4'he) |=>
      (~op_n_q & $past(wdata, 2) & 8'hae) == 8'h00;
  endproperty
  a_op_clr: assert property (p_op_clr) else $error("cleared bit pin not high");
  property p_irq_off;
    wr_stb && addr == 4'h5 && wdata == 8'h00 ##1 !wr_stb |=> irq_n_q;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with all masks off");
  property p_irq_cause;
    !irq_n_q |-> (mask_q | mask_old_q) != 8'h00;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without mask");
  property p_tx_run;
    $rose(txd_q) |-> low_q != 0 && low_q % (set2_q ? BIT_SET2 : BIT_SET1) == 0;
  endproperty
  a_tx_run: assert property (p_tx_run) else $error("bit time off baud set");
  property p_tx_start;
    $fell(txd_q) |-> !txd_q [*8];
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start bit too short");
endmodule

bind duart_mode1_and_irq_regs duart_regs_checker chk_i (.mclk(mclk), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q),
  .rxd(rxd), .txd_q(txd_q), .in_port(in_port), .op_n_q(op_n_q), .irq_n_q(irq_n_q));

// ---- dv/remote_serial.sv ----
/*
  Remote serial device: sends frames on the receive line, samples
  frames from the transmit line. Assumes BIT_CYC mclk cycles a bit.
*/
module remote_serial #(
  parameter int BIT_CYC = 2080
) (
  // clock
  input logic mclk,
  // serial lines
  output logic line_out,
  input logic line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line_out = 1'b1;

  // ****
  // start, n data bits lsb first, parity, stop
  // ****
  task automatic send(input logic [7:0] d, input int n, input logic par);
    for (int i = -1; i <= n + 1; i++) begin
      @(posedge mclk);
      line_out <= (i < 0) ? 1'b0 : (i < n) ? d[i] : (i == n) ? par : 1'b1;
      repeat (BIT_CYC - 1) @(posedge mclk);
    end
  endtask

  // ****
  // n bits after start sampled mid-bit, then stop
  // ****
  task automatic recv(input int n, output logic [9:0] v);
    v = 10'h000;
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge mclk);
    for (int i = 0; i <= n; i++) begin
      repeat (BIT_CYC) @(posedge mclk);
      v[i] = line_in;
    end
  endtask
endmodule

// ---- dv/tb.sv ----
/*
  Testbench of the channel A register block: strobe-port register
  tests, then full-duplex frames. Assumes constants header on path.
*/
`include "duart_defines.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CYC = 16 * `BAUD_DIV_SET2;
  logic mclk;
  logic rst_n;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] rdata_q;
  logic rxd;
  logic txd_q;
  logic [3:0] in_port;
  logic [7:0] op_n_q;
  logic irq_n_q;
  int failures;
  int checks_done;
  int cycles;
  logic [7:0] modes [3] = '{8'h03, 8'h5e, 8'h2c};
  logic [7:0] rx_byte [3] = '{8'h3c, 8'h55, 8'h0a};
  logic rx_par [3] = '{1'b1, 1'b1, 1'b0};

  duart_mode1_and_irq_regs dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_q(rdata_q), .rxd(rxd), .txd_q(txd_q),
    .in_port(in_port), .op_n_q(op_n_q), .irq_n_q(irq_n_q));
  remote_serial #(.BIT_CYC(BIT_CYC)) peer (.mclk(mclk), .line_out(rxd), .line_in(txd_q));

  // ****
  // tasks
  // ****
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    chk(10'(rdata_q), 10'(exp));
  endtask
  task automatic end_sim();
    $display("checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****
  // clock and timeout
  // ****
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 95000) begin
      failures++;
      end_sim();
    end
  end

  // ****
  // main sequence
  // ****
  initial begin
    logic [9:0] got;
    logic [7:0] m;
    logic p;
    int len;
    int mk;
    int e;
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    in_port = 4'h0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h07);
    rd(4'h0, 8'h07);
    wr(4'h2, 8'h10);
    wr(4'h0, 8'h81);
    rd(4'h0, 8'h07);
    wr(4'h2, 8'h10);
    rd(4'h0, 8'h81);
    rd(4'h5, 8'h00);
    rd(4'h6, 8'h00);
    rd(4'h2, 8'h00);
    wr(4'h2, 8'h05);
    rd(4'h5, 8'h01);
    wr(4'h5, 8'h01);
    repeat (2) @(posedge mclk);
    #1 chk(10'(irq_n_q), 10'h000);
    wr(4'h5, 8'h00);
    repeat (2) @(posedge mclk);
    #1 chk(10'(irq_n_q), 10'h001);
    wr(4'he, 8'hff);
    @(posedge mclk);
    #1 chk(10'(op_n_q), 10'h000);
    wr(4'hf, 8'h5a);
    @(posedge mclk);
    #1 chk(10'(op_n_q), 10'h05a);
    wr(4'hd, 8'h10);
    @(posedge mclk);
    #1 chk(10'(op_n_q), 10'h05a);
    wr(4'h4, 8'h80);
    for (int r = 0; r < 3; r++) begin
      m = modes[r];
      len = m[1:0] + 5;
      mk = (1 << len) - 1;
      p = m[3] ? m[2] : (^(8'ha5 & 8'(mk)) ^ m[2]);
      e = (8'ha5 & mk) | (p << len) | (1 << (len + 1));
      wr(4'h2, 8'h10);
      wr(4'h0, m);
      wr(4'h2, 8'h40);
      wr(4'h3, 8'ha5);
      fork
        peer.send(rx_byte[r], len, rx_par[r]);
        peer.recv(len + 1, got);
      join
      repeat (BIT_CYC) @(posedge mclk);
      chk(got, 10'(e));
      rd(4'h1, 8'h2d);
      rd(4'h5, m[6] ? 8'h01 : 8'h03);
      #1 chk(10'(op_n_q), m[6] ? 10'h05a : 10'h04a);
      rd(4'h3, rx_byte[r] & 8'(mk));
      rd(4'h1, m[5] ? 8'h2c : 8'h0c);
      wr(4'h2, 8'h40);
      rd(4'h1, 8'h0c);
    end
    @(posedge mclk);
    in_port <= 4'h5;
    repeat (4) @(posedge mclk);
    rd(4'h4, 8'h55);
    rd(4'h4, 8'h05);
    rd(4'hd, 8'h05);
    wr(4'h2, 8'h08);
    wr(4'h3, 8'h5a);
    rd(4'h1, 8'h08);
    end_sim();
  end
endmodule

// ---- logic/duart_defines.vh ----
/*
  Constants of the channel A mode/interrupt register block: register
  offsets, command codes, field positions, reset values, baud divisors.
  Assumes a 4-bit register address and a 40 MHz mclk.
*/
// Function
// - pointer returns to mode one on reset/command
// - mode one access moves pointer to mode two
// - flow control negates request-to-send on a valid start bit when full
// - output bit kept; request-to-send returns when space
// - bit 6 picks ready or full interrupt source
// - character mode shows top character error bits
// - block mode ORs errors since error reset
// - parity appended on transmit, checked on receive
// - parity mode 11 is multidrop address bit
// - parity type picks sense, level or polarity
// - length field sets data bits per character
// - aux control bit 7 picks baud set
// - output pins are inverse of port bits, except OP0 under flow control and OP4/OP6 when configured
`ifndef DUART_DEFINES_VH
`define DUART_DEFINES_VH

// ****************************************
// register offsets
// ****************************************
`define ADDR_MODE 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_CMD 4'h2
`define ADDR_DATA 4'h3
`define ADDR_IPC_ACR 4'h4
`define ADDR_ISR_IMR 4'h5
`define ADDR_PRE_HI 4'h6
`define ADDR_PRE_LO 4'h7
`define ADDR_OUTPUT_PORT_CONFIG_IP 4'hd
`define ADDR_OP_SET 4'he
`define ADDR_OP_CLR 4'hf

// ****************************************
// command codes, bits 6:4
// ****************************************
`define CMD_SET_PTR 3'h1
`define CMD_RX_RST 3'h2
`define CMD_TX_RST 3'h3
`define CMD_ERR_RST 3'h4
`define CMD_BRK_RST 3'h5

// ****************************************
// fields and reset values
// ****************************************
`define M1_RX_FLOW 7
`define M1_RX_INT 6
`define M1_ERR_BLK 5
`define ACR_BRG_SET 7
`define OUTPUT_PORT_CONFIG_OP4 4
`define OUTPUT_PORT_CONFIG_OP6 6
`define PAR_WITH 2'h0
`define PAR_FORCE 2'h1
`define PAR_NONE 2'h2
`define PAR_MULTI 2'h3
`define REG_RESET 8'h00

// ****************************************
// 16x baud divisors for the two sets
// ****************************************
`define BAUD_DIV_SET1 16'h0104
`define BAUD_DIV_SET2 16'h0082

`endif

// ---- logic/duart_mode1_and_irq_regs.v ----
/*
  Channel A of a dual asynchronous receiver/transmitter: mode pointer,
  mode one behaviour, 4-deep receive FIFO, 2-entry transmit buffer,
  input change, interrupt status/mask and output port.
  Assumes a single-cycle register port and one 40 MHz clock.
*/
// Our own choices: the address-and-strobe port and the placing of the registers.
`include "duart_defines.vh"

module duart_mode1_and_irq_regs (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // register port
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata_q,
  // serial line
  input wire rxd,
  output reg txd_q,
  // input port
  input wire [3:0] in_port,
  // output port pins and interrupt
  output reg [7:0] op_n_q,
  output reg irq_n_q
);

  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_PAR = 3'h3;
  localparam ST_STOP = 3'h4;
  localparam ST_BRK = 3'h5;

  // ****************************************
  // decode helpers
  // ****************************************
  function [7:0] len_mask;
    input [1:0] cl;
    begin
      case (cl)
        2'h0: len_mask = 8'h1f;
        2'h1: len_mask = 8'h3f;
        2'h2: len_mask = 8'h7f;
        default: len_mask = 8'hff;
      endcase
    end
  endfunction

  function par_of;
    input [7:0] d;
    input [1:0] cl;
    begin
      par_of = ^(d & len_mask(cl));
    end
  endfunction

  // ****************************************
  // register state
  // ****************************************
  reg ptr_q;
  reg [7:0] mode_one_q, mode_two_q, aux_control_q, irq_mask_q;
  reg [7:0] timer_preload_high_q, timer_preload_low_q;
  reg [7:0] output_port_config_q, output_port_value_q;
  reg rx_en_q, tx_en_q;

  wire mode_acc = (wr_stb || rd_stb) && addr == `ADDR_MODE;
  wire cmd_wr = wr_stb && addr == `ADDR_CMD;
  wire set_ptr = cmd_wr && wdata[6:4] == `CMD_SET_PTR;
  wire rx_rst = cmd_wr && wdata[6:4] == `CMD_RX_RST;
  wire tx_rst = cmd_wr && wdata[6:4] == `CMD_TX_RST;
  wire err_rst = cmd_wr && wdata[6:4] == `CMD_ERR_RST;
  wire brk_rst = cmd_wr && wdata[6:4] == `CMD_BRK_RST;
  wire [1:0] par_mode = mode_one_q[4:3];
  wire par_type = mode_one_q[2];
  wire par_en = par_mode != `PAR_NONE;
  wire [2:0] last_bit = {1'b0, mode_one_q[1:0]} + 3'h4;

  always @(posedge mclk) begin
    if (!rst_n) begin
      ptr_q <= 1'b0;
      mode_one_q <= `REG_RESET;
      mode_two_q <= `REG_RESET;
      aux_control_q <= `REG_RESET;
      irq_mask_q <= `REG_RESET;
      timer_preload_high_q <= `REG_RESET;
      timer_preload_low_q <= `REG_RESET;
      output_port_config_q <= `REG_RESET;
      output_port_value_q <= `REG_RESET;
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
    end else begin
      if (set_ptr) begin
        ptr_q <= 1'b0;
      end else if (mode_acc && !ptr_q) begin
        ptr_q <= 1'b1;
      end
      if (wr_stb && addr == `ADDR_MODE && !ptr_q) begin
        mode_one_q <= wdata;
      end
      if (wr_stb && addr == `ADDR_MODE && ptr_q) begin
        mode_two_q <= wdata;
      end
      if (wr_stb && addr == `ADDR_IPC_ACR) begin
        aux_control_q <= wdata;
      end
      if (wr_stb && addr == `ADDR_ISR_IMR) begin
        irq_mask_q <= wdata;
      end
      if (wr_stb && addr == `ADDR_PRE_HI) begin
        timer_preload_high_q <= wdata;
      end
      if (wr_stb && addr == `ADDR_PRE_LO) begin
        timer_preload_low_q <= wdata;
      end
      if (wr_stb && addr == `ADDR_OUTPUT_PORT_CONFIG_IP) begin
        output_port_config_q <= wdata;
      end
      if (wr_stb && addr == `ADDR_OP_SET) begin
        output_port_value_q <= output_port_value_q | wdata;
      end else if (wr_stb && addr == `ADDR_OP_CLR) begin
        output_port_value_q <= output_port_value_q & ~wdata;
      end
      if (rx_rst || (cmd_wr && wdata[1])) begin
        rx_en_q <= 1'b0;
      end else if (cmd_wr && wdata[0]) begin
        rx_en_q <= 1'b1;
      end
      if (tx_rst || (cmd_wr && wdata[3])) begin
        tx_en_q <= 1'b0;
      end else if (cmd_wr && wdata[2]) begin
        tx_en_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // 16x baud tick
  // ****************************************
  reg [15:0] div_q;
  reg tick_q;
  wire [15:0] div_max = aux_control_q[`ACR_BRG_SET] ? `BAUD_DIV_SET2 : `BAUD_DIV_SET1;

  always @(posedge mclk) begin
    if (!rst_n || div_q >= div_max - 16'h0001) begin
      div_q <= 16'h0000;
      tick_q <= rst_n;
    end else begin
      div_q <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // ****************************************
  // synchronisers
  // ****************************************
  reg rxs1_q, rxs2_q;
  reg [3:0] ips1_q, ips2_q, ips3_q, delta_q;

  always @(posedge mclk) begin
    if (!rst_n) begin
      rxs1_q <= 1'b1;
      rxs2_q <= 1'b1;
      ips1_q <= 4'h0;
      ips2_q <= 4'h0;
      ips3_q <= 4'h0;
    end else begin
      rxs1_q <= rxd;
      rxs2_q <= rxs1_q;
      ips1_q <= in_port;
      ips2_q <= ips1_q;
      ips3_q <= ips2_q;
    end
  end

  // ****************************************
  // receiver and FIFO
  // ****************************************
  reg [2:0] rx_st_q, rx_bit_q;
  reg [3:0] rx_tk_q;
  reg [7:0] rx_sh_q;
  reg rx_par_q;
  reg [10:0] fifo_q [0:3];
  reg [1:0] wp_q, rp_q;
  reg [2:0] cnt_q;
  reg flow_neg_q, ovr_q, brk_q;
  reg [2:0] acc_q;

  wire full = cnt_q == 3'h4;
  wire [10:0] top = fifo_q[rp_q];
  wire [2:0] top_err = (cnt_q != 3'h0) ? top[10:8] : 3'h0;
  wire pop = rd_stb && addr == `ADDR_DATA && cnt_q != 3'h0;
  wire rx_mid = tick_q && rx_tk_q == 4'hf;
  wire push = rx_mid && rx_st_q == ST_STOP;
  wire start_ok = tick_q && rx_st_q == ST_START && rx_tk_q == 4'h7 && !rxs2_q;
  wire rx_fe = !rxs2_q;
  wire rx_brk = rx_fe && rx_sh_q == 8'h00 && !(par_en && rx_par_q);
  reg rx_pe;

  always @* begin
    case (par_mode)
      `PAR_WITH: rx_pe = (rx_par_q ^ par_of(rx_sh_q, mode_one_q[1:0])) != par_type;
      `PAR_FORCE: rx_pe = rx_par_q != par_type;
      `PAR_MULTI: rx_pe = rx_par_q;
      default: rx_pe = 1'b0;
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n || rx_rst) begin
      rx_st_q <= ST_IDLE;
      rx_tk_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_par_q <= 1'b0;
    end else if (tick_q) begin
      rx_tk_q <= rx_tk_q + 4'h1;
      case (rx_st_q)
        ST_IDLE: begin
          rx_tk_q <= 4'h0;
          if (rx_en_q && !rxs2_q) begin
            rx_st_q <= ST_START;
          end
        end
        ST_START: begin
          if (rx_tk_q == 4'h7) begin
            rx_tk_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
            rx_st_q <= rxs2_q ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_tk_q == 4'hf) begin
            rx_sh_q[rx_bit_q] <= rxs2_q;
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == last_bit) begin
              rx_st_q <= par_en ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (rx_tk_q == 4'hf) begin
            rx_par_q <= rxs2_q;
            rx_st_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (rx_tk_q == 4'hf) begin
            rx_par_q <= 1'b0;
            rx_st_q <= rx_brk ? ST_BRK : ST_IDLE;
          end
        end
        ST_BRK: begin
          if (rxs2_q) begin
            rx_st_q <= ST_IDLE;
          end
        end
        default: rx_st_q <= ST_IDLE;
      endcase
    end
  end

  always @(posedge mclk) begin
    if (!rst_n || rx_rst) begin
      wp_q <= 2'h0;
      rp_q <= 2'h0;
      cnt_q <= 3'h0;
    end else begin
      if (push && !full) begin
        fifo_q[wp_q] <= {rx_brk, rx_fe, rx_pe && par_en, rx_sh_q};
        wp_q <= wp_q + 2'h1;
      end
      if (pop) begin
        rp_q <= rp_q + 2'h1;
      end
      cnt_q <= cnt_q + {2'h0, push && !full} - {2'h0, pop};
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      flow_neg_q <= 1'b0;
      ovr_q <= 1'b0;
      brk_q <= 1'b0;
      acc_q <= 3'h0;
    end else begin
      flow_neg_q <= (flow_neg_q && full) || (start_ok && full && mode_one_q[`M1_RX_FLOW]);
      ovr_q <= (ovr_q && !err_rst && !rx_rst) || (push && full);
      brk_q <= (brk_q && !brk_rst) || (push && rx_brk);
      acc_q <= ((err_rst || rx_rst) ? 3'h0 : acc_q) | top_err;
    end
  end

  wire [2:0] err_bits = mode_one_q[`M1_ERR_BLK] ? acc_q : top_err;

  // ****************************************
  // transmit buffer and transmitter
  // ****************************************
  reg [7:0] tb_q [0:1];
  reg [1:0] tb_cnt_q;
  reg [2:0] tx_st_q, tx_bit_q;
  reg [3:0] tx_tk_q;
  reg [7:0] tx_sh_q;
  reg tx_pb_q;

  wire tx_ready = tx_en_q && tb_cnt_q != 2'h2;
  wire tb_push = wr_stb && addr == `ADDR_DATA && tx_ready;
  wire tb_pop = tick_q && tx_st_q == ST_IDLE && tx_en_q && tb_cnt_q != 2'h0;
  wire tx_empty = tb_cnt_q == 2'h0 && tx_st_q == ST_IDLE;
  wire [7:0] tb_head = tb_q[0] & len_mask(mode_one_q[1:0]);
  wire tx_par = (par_mode == `PAR_WITH) ?
    (par_of(tb_head, mode_one_q[1:0]) ^ par_type) : par_type;

  always @(posedge mclk) begin
    if (!rst_n || tx_rst) begin
      tb_cnt_q <= 2'h0;
    end else begin
      if (tb_pop) begin
        tb_q[0] <= (tb_push && tb_cnt_q == 2'h1) ? wdata : tb_q[1];
      end else if (tb_push && tb_cnt_q == 2'h0) begin
        tb_q[0] <= wdata;
      end
      if (tb_push && (tb_cnt_q == 2'h1) != tb_pop) begin
        tb_q[1] <= wdata;
      end
      tb_cnt_q <= tb_cnt_q + {1'b0, tb_push} - {1'b0, tb_pop};
    end
  end

  always @(posedge mclk) begin
    if (!rst_n || tx_rst) begin
      tx_st_q <= ST_IDLE;
      tx_tk_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_pb_q <= 1'b0;
      txd_q <= 1'b1;
    end else if (tick_q) begin
      tx_tk_q <= tx_tk_q + 4'h1;
      case (tx_st_q)
        ST_IDLE: begin
          tx_tk_q <= 4'h0;
          if (tb_pop) begin
            tx_sh_q <= tb_head;
            tx_pb_q <= tx_par;
            txd_q <= 1'b0;
            tx_st_q <= ST_START;
          end
        end
        ST_START: begin
          if (tx_tk_q == 4'hf) begin
            txd_q <= tx_sh_q[0];
            tx_bit_q <= 3'h0;
            tx_st_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tx_tk_q == 4'hf) begin
            tx_bit_q <= tx_bit_q + 3'h1;
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            if (tx_bit_q == last_bit) begin
              txd_q <= par_en ? tx_pb_q : 1'b1;
              tx_st_q <= par_en ? ST_PAR : ST_STOP;
            end else begin
              txd_q <= tx_sh_q[1];
            end
          end
        end
        ST_PAR: begin
          if (tx_tk_q == 4'hf) begin
            txd_q <= 1'b1;
            tx_st_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tx_tk_q == 4'hf) begin
            tx_st_q <= ST_IDLE;
          end
        end
        default: tx_st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // status, interrupt, output port, read
  // ****************************************
  wire rx_src = mode_one_q[`M1_RX_INT] ? full : cnt_q != 3'h0;
  wire ipc_rd = rd_stb && addr == `ADDR_IPC_ACR;
  wire ip_chg = |(delta_q & aux_control_q[3:0]);
  wire [7:0] irq_status = {ip_chg, 4'h0, brk_q, rx_src, tx_ready};
  wire [7:0] status = {err_bits, ovr_q, tx_empty, tx_ready, full, cnt_q != 3'h0};
  reg [7:0] op_v;
  reg [7:0] rd_mux;

  always @* begin
    op_v = output_port_value_q;
    op_v[0] = output_port_value_q[0] && !flow_neg_q;
    if (output_port_config_q[`OUTPUT_PORT_CONFIG_OP4]) begin
      op_v[4] = rx_src;
    end
    if (output_port_config_q[`OUTPUT_PORT_CONFIG_OP6]) begin
      op_v[6] = tx_ready;
    end
  end

  always @* begin
    case (addr)
      `ADDR_MODE: rd_mux = ptr_q ? mode_two_q : mode_one_q;
      `ADDR_STATUS: rd_mux = status;
      `ADDR_DATA: rd_mux = top[7:0];
      `ADDR_IPC_ACR: rd_mux = {delta_q, ips2_q};
      `ADDR_ISR_IMR: rd_mux = irq_status;
      `ADDR_OUTPUT_PORT_CONFIG_IP: rd_mux = {4'h0, ips2_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      delta_q <= 4'h0;
      rdata_q <= 8'h00;
      op_n_q <= 8'hff;
      irq_n_q <= 1'b1;
    end else begin
      delta_q <= (delta_q & {4{!ipc_rd}}) | (ips2_q ^ ips3_q);
      rdata_q <= rd_stb ? rd_mux : 8'h00;
      op_n_q <= ~op_v;
      irq_n_q <= ~|(irq_status & irq_mask_q);
    end
  end

endmodule
